// *** hw/tpc_pkg.sv ***
package tpc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned TICK_HZ = 2_500_000;
  localparam int unsigned TICK_DIV = SYS_CLK_HZ / TICK_HZ;
  localparam logic [7:0] TICK_LIMIT_FULL = 8'(TICK_DIV);
  localparam logic [7:0] TICK_LIMIT_HALF = 8'(2 * TICK_DIV);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 13;
  localparam logic [11:0] REG_CLK_CTRL = 12'h000;
  localparam logic [11:0] REG_MOD_PERIOD = 12'h004;
  localparam logic [11:0] REG_MOD_DUTY = 12'h008;
  localparam logic [11:0] REG_BIT_IO = 12'h00C;
  localparam logic [3:0] CH_PAGE = 4'h1;
  localparam logic [1:0] CH_CTRL = 2'h0;
  localparam logic [1:0] CH_PERIOD = 2'h1;
  localparam logic [1:0] CH_DUTY = 2'h2;
  localparam logic [1:0] CH_RESULT = 2'h3;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HALVE_BIT = 0;
  localparam int unsigned CLK_RESTORE_BIT = 1;
  localparam int unsigned CTRL_POL_BIT = 0;
  localparam int unsigned CTRL_CAP_BIT = 1;
  localparam int unsigned CTRL_ARM_BIT = 2;
  localparam int unsigned CTRL_DONE_BIT = 4;
  localparam int unsigned BIO_OUT_BIT = 0;
  localparam int unsigned BIO_OE_BIT = 1;
  localparam int unsigned BIO_IN_BIT = 2;
  localparam logic [15:0] MOD_PERIOD_MASK = 16'h7FFF;
  localparam logic [15:0] DUTY_FULL = 16'hFFFF;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [15:0] DUTY_RESET = 16'h0000;

  typedef enum logic [3:0] {
    CAP_IDLE = 4'b0001,
    CAP_WAIT = 4'b0010,
    CAP_TIME = 4'b0100,
    CAP_DONE = 4'b1000
  } tpc_cap_state_t;

  // High while the tick count sits below duty scaled onto the period.
  function automatic logic dutyOn(input logic [15:0] cnt, input logic [15:0] period, input logic [15:0] duty);
    logic [31:0] prod;
    prod = 32'(duty) * 32'(period);
    dutyOn = (duty == DUTY_FULL) || (cnt < prod[31:16]);
  endfunction : dutyOn

endpackage : tpc_pkg

// *** hw/tpc_tickgen.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpc_tickgen (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic halved,
  // Timebase
  output logic tick
);
  import tpc_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tpc_tick_st_t;

  tpc_tick_st_t st, next_st;
  logic [7:0] limit;

  // Halving stretches every tick, so all derived rates halve together.
  assign limit = halved ? TICK_LIMIT_HALF : TICK_LIMIT_FULL;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= limit - 8'h01) begin
      next_st.cnt = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  // Helper logic for the spacing check: clocks since the last tick, and whether the rate held steady since.
  logic [7:0] sinceTick;
  logic steady;
  logic steadyHalved;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sinceTick <= 8'h00;
      steady <= 1'b0;
      steadyHalved <= 1'b0;
    end else begin
      if (tick) begin
        sinceTick <= 8'h01;
        steady <= 1'b1;
        steadyHalved <= halved;
      end else begin
        if (sinceTick != 8'hFF) begin
          sinceTick <= sinceTick + 8'h01;
        end
        if (halved != steadyHalved) begin
          steady <= 1'b0;
        end
      end
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    (tick && steady && halved == steadyHalved) |-> sinceTick == (steadyHalved ? TICK_LIMIT_HALF : TICK_LIMIT_FULL))
    else $error("tick spacing wrong for the selected rate");

endmodule : tpc_tickgen
`default_nettype wire

// *** hw/tpc_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpc_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  // Register access
  input wire logic wrEn,
  input wire logic [1:0] regSel,
  input wire logic [31:0] wdata,
  // Pin
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  // State
  output logic polarity,
  output logic capMode,
  output logic done,
  output logic [15:0] period,
  output logic [15:0] duty,
  output logic [15:0] result
);
  import tpc_pkg::*;

  typedef struct packed {
    tpc_cap_state_t state;
    logic pol;
    logic cap;
    logic [15:0] period;
    logic [15:0] duty;
    logic sync1;
    logic sync2;
    logic prevAct;
    logic [15:0] cnt;
    logic [15:0] width;
    logic [15:0] pwmCnt;
    logic pin;
  } tpc_ch_st_t;

  tpc_ch_st_t st, next_st;
  logic act;

  // Active level follows the polarity: low pulses are timed when inverted.
  assign act = st.sync2 ^ st.pol;

  always_comb begin
    next_st = st;
    next_st.sync1 = pinIn;
    next_st.sync2 = st.sync1;
    next_st.prevAct = act;
    if (tick) begin
      next_st.pwmCnt = (st.pwmCnt + 16'h0001 >= st.period) ? 16'h0000 : st.pwmCnt + 16'h0001;
    end
    next_st.pin = dutyOn(st.pwmCnt, st.period, st.duty) ^ st.pol;
    case (st.state)
      CAP_WAIT: begin
        if (act && !st.prevAct) begin
          next_st.state = CAP_TIME;
          next_st.cnt = 16'h0000;
        end
      end
      CAP_TIME: begin
        if (!act) begin
          next_st.state = CAP_DONE;
          next_st.width = (st.cnt == 16'h0000) ? 16'h0001 : st.cnt;
        end else if (tick && st.cnt != 16'hFFFF) begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
      CAP_IDLE, CAP_DONE: begin
        next_st.state = st.state;
      end
      default: begin
        next_st.state = CAP_IDLE;
      end
    endcase
    if (wrEn) begin
      case (regSel)
        CH_CTRL: begin
          next_st.pol = wdata[CTRL_POL_BIT];
          next_st.cap = wdata[CTRL_CAP_BIT] | wdata[CTRL_ARM_BIT];
          if (wdata[CTRL_ARM_BIT]) begin
            next_st.state = CAP_WAIT;
          end else if (!wdata[CTRL_CAP_BIT]) begin
            next_st.state = CAP_IDLE;
          end
        end
        CH_PERIOD: next_st.period = wdata[15:0];
        CH_DUTY: next_st.duty = wdata[15:0];
        default: next_st.period = st.period;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '{state: CAP_IDLE, period: PERIOD_RESET, duty: DUTY_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign pinOut = st.pin;
  assign pinOe = !st.cap;
  assign polarity = st.pol;
  assign capMode = st.cap;
  assign done = (st.state == CAP_DONE);
  assign period = st.period;
  assign duty = st.duty;
  // Zero until a whole pulse is in; repeated reads stay at the nonzero width.
  assign result = done ? st.width : 16'h0000;

  a_wait_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (st.state == CAP_WAIT && !(act && !st.prevAct) && !wrEn) |=> st.state == CAP_WAIT)
    else $error("capture left wait without an edge");
  a_start_edge: assert property (@(posedge clk) disable iff (sys_rst)
    (st.state == CAP_WAIT && act && !st.prevAct && !wrEn) |=> st.state == CAP_TIME && st.cnt == 16'h0000)
    else $error("start edge missed");
  a_end_edge: assert property (@(posedge clk) disable iff (sys_rst)
    (st.state == CAP_TIME && !act && !wrEn) |=> done && result == (($past(st.cnt) == 16'h0000) ? 16'h0001 : $past(st.cnt)))
    else $error("end edge did not stop count");
  a_result_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !done |-> result == 16'h0000) else $error("result nonzero before done");
  a_result_valid: assert property (@(posedge clk) disable iff (sys_rst)
    done |-> result != 16'h0000) else $error("done with zero result");
  c_pulse_done: cover property (@(posedge clk) disable iff (sys_rst) st.state == CAP_TIME ##[1:200] done);
  c_inverted: cover property (@(posedge clk) disable iff (sys_rst) st.pol && done);

endmodule : tpc_channel
`default_nettype wire

// *** hw/tpc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Halving command doubles tick spacing, halving every derived rate.
// - Restore command returns the timebase to full speed.
// - Halving acts the same whether issued before or after the period.
// - Polarity exists on timer pins only; modulator pin has none.
// - Non-inverted timer output is high for the duty fraction.
// - Inverted timer output is low for the duty fraction.
// - Arm makes the pin an input and waits for an edge into active.
// - Count ticks while active; the edge out of active stops it.
// - Result reads zero before the start edge and while timing.
// - First read after a whole pulse returns the nonzero width.
// - Later reads without re-arming return a nonzero value.
// - Width counts 2.5 MHz ticks at full rate, 0.4 us each, unsigned.
// - Arm and result read complete at once, never waiting for a pulse.
// - Non-inverted polarity times the high part of the input.
// - Inverted polarity times the low part of the input.
// - Thirteen capture channels; the fourth D pin is plain bit I/O.
// - Duty is unsigned 16-bit, zero always off, maximum always on.
module tpc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Timer pins
  input wire logic [tpc_pkg::NUM_CH-1:0] timerPinIn,
  output logic [tpc_pkg::NUM_CH-1:0] timerPinOut,
  output logic [tpc_pkg::NUM_CH-1:0] timerPinOe,
  // Fourth D-group timer pin, bit I/O only
  input wire logic fourthDGroupTimerPinIn,
  output logic fourthDGroupTimerPinOut,
  output logic fourthDGroupTimerPinOe,
  // Modulator pin and status
  output logic modulatorPin,
  output logic clkHalved
);
  import tpc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic halved;
    logic [15:0] modPeriod;
    logic [15:0] modDuty;
    logic [15:0] modCnt;
    logic modPin;
    logic bioOut;
    logic bioOe;
  } tpc_top_st_t;

  tpc_top_st_t st, next_st;
  logic tick;
  logic wrFire;
  logic [NUM_CH-1:0] chWr;
  logic [NUM_CH-1:0] chPol;
  logic [NUM_CH-1:0] chCap;
  logic [NUM_CH-1:0] chDone;
  logic [NUM_CH-1:0] chPin;
  logic [NUM_CH-1:0] chOe;
  logic [15:0] chPeriod [NUM_CH];
  logic [15:0] chDuty [NUM_CH];
  logic [15:0] chResult [NUM_CH];

  // A channel address is valid on the channel page below the channel count.
  function automatic logic chHit(input logic [11:0] addr);
    chHit = (addr[11:8] == CH_PAGE) && (32'(addr[7:4]) < NUM_CH) && (addr[1:0] == 2'b00);
  endfunction : chHit

  // Writes land only on the completing access edge.
  assign wrFire = psel && penable && pready && pwrite;

  // ----------------------------------------------------------------
  // Timebase and channels
  // ----------------------------------------------------------------
  // One tick source serves all channels, so halving needs no period rescaling.
  tpc_tickgen u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .halved(st.halved),
    .tick(tick)
  );

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      assign chWr[i] = wrFire && chHit(paddr) && (32'(paddr[7:4]) == i);
      tpc_channel u_ch (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .wrEn(chWr[i]),
        .regSel(paddr[3:2]),
        .wdata(pwdata),
        .pinIn(timerPinIn[i]),
        .pinOut(chPin[i]),
        .pinOe(chOe[i]),
        .polarity(chPol[i]),
        .capMode(chCap[i]),
        .done(chDone[i]),
        .period(chPeriod[i]),
        .duty(chDuty[i]),
        .result(chResult[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] ch;
    ch = paddr[7:4];
    next_st = st;
    // One wait state: the answer is ready on the second access edge, pulse or no pulse.
    next_st.pready = psel && !penable;
    if (psel && !penable) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
      if (chHit(paddr)) begin
        case (paddr[3:2])
          CH_CTRL: begin
            next_st.prdata[CTRL_POL_BIT] = chPol[ch];
            next_st.prdata[CTRL_CAP_BIT] = chCap[ch];
            next_st.prdata[CTRL_DONE_BIT] = chDone[ch];
          end
          CH_PERIOD: next_st.prdata[15:0] = chPeriod[ch];
          CH_DUTY: next_st.prdata[15:0] = chDuty[ch];
          default: next_st.prdata[15:0] = chResult[ch];
        endcase
      end else begin
        case (paddr)
          REG_CLK_CTRL: next_st.prdata[CLK_HALVE_BIT] = st.halved;
          REG_MOD_PERIOD: next_st.prdata[15:0] = st.modPeriod;
          REG_MOD_DUTY: next_st.prdata[15:0] = st.modDuty;
          REG_BIT_IO: begin
            next_st.prdata[BIO_OUT_BIT] = st.bioOut;
            next_st.prdata[BIO_OE_BIT] = st.bioOe;
            next_st.prdata[BIO_IN_BIT] = fourthDGroupTimerPinIn;
          end
          default: next_st.pslverr = 1'b1;
        endcase
      end
    end
    if (wrFire && !pslverr) begin
      case (paddr)
        REG_CLK_CTRL: begin
          if (pwdata[CLK_RESTORE_BIT]) begin
            next_st.halved = 1'b0;
          end else if (pwdata[CLK_HALVE_BIT]) begin
            next_st.halved = 1'b1;
          end
        end
        REG_MOD_PERIOD: next_st.modPeriod = pwdata[15:0] & MOD_PERIOD_MASK;
        REG_MOD_DUTY: next_st.modDuty = pwdata[15:0];
        REG_BIT_IO: begin
          next_st.bioOut = pwdata[BIO_OUT_BIT];
          next_st.bioOe = pwdata[BIO_OE_BIT];
        end
        default: next_st.bioOe = st.bioOe;
      endcase
    end
    if (tick) begin
      next_st.modCnt = (st.modCnt + 16'h0001 >= st.modPeriod) ? 16'h0000 : st.modCnt + 16'h0001;
    end
    // No polarity term here: inversion of this pin is done by the duty value alone.
    next_st.modPin = dutyOn(st.modCnt, st.modPeriod, st.modDuty);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '{modPeriod: PERIOD_RESET, modDuty: DUTY_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign timerPinOut = chPin;
  assign timerPinOe = chOe;
  assign fourthDGroupTimerPinOut = st.bioOut;
  assign fourthDGroupTimerPinOe = st.bioOe;
  assign modulatorPin = st.modPin;
  assign clkHalved = st.halved;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_apb_one_wait: assert property ((psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not one wait state");
  a_halve_cmd: assert property ((wrFire && !pslverr && paddr == REG_CLK_CTRL && pwdata[1:0] == 2'b01)
    |=> clkHalved) else $error("halving command ignored");
  a_restore_cmd: assert property ((wrFire && !pslverr && paddr == REG_CLK_CTRL && pwdata[CLK_RESTORE_BIT])
    |=> !clkHalved) else $error("restore command ignored");
  a_mod_full: assert property ((st.modDuty == DUTY_FULL) ##1 (st.modDuty == DUTY_FULL) |-> modulatorPin)
    else $error("full duty not always on");
  a_mod_zero: assert property ((st.modDuty == 16'h0000) ##1 (st.modDuty == 16'h0000) |-> !modulatorPin)
    else $error("zero duty not always off");
  a_arm_input: assert property ((wrFire && chHit(paddr) && paddr[3:2] == CH_CTRL && pwdata[CTRL_ARM_BIT])
    |=> !timerPinOe[$past(paddr[7:4])] ##1 !timerPinOe[$past(paddr[7:4], 2)]) else $error("arm left pin driving");
  c_halved: cover property (clkHalved ##[1:100] !clkHalved);
  c_read_result: cover property (psel && penable && pready && !pwrite && chHit(paddr) && prdata != 32'h0);
  c_unmapped: cover property (pslverr && pready);

endmodule : tpc_top
`default_nettype wire

// *** tb/tpc_pulse_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpc_pulse_src (
  // Clock
  input wire logic clk,
  // Pins toward the block
  output logic [tpc_pkg::NUM_CH-1:0] pin,
  output logic bitPin
);
  import tpc_pkg::*;

  // ----------------------------------------------------------------
  // Pulse source
  // ----------------------------------------------------------------
  // Lines rest at the level chosen last, so an idle pin never floats.
  initial begin
    pin = '0;
    bitPin = 1'b0;
  end

  task automatic setLevel(input int ch, input logic v);
    @(posedge clk);
    pin[ch] <= v;
  endtask : setLevel

  task automatic setBit(input logic v);
    @(posedge clk);
    bitPin <= v;
  endtask : setBit

  // One pulse at the active level, held for a whole number of clocks.
  task automatic pulse(input int ch, input logic act, input int n);
    @(posedge clk);
    pin[ch] <= act;
    repeat (n) @(posedge clk);
    pin[ch] <= ~act;
  endtask : pulse
endmodule : tpc_pulse_src
`default_nettype wire

// *** tb/test_timer_pulse_width_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_timer_pulse_width_capture;
  import tpc_pkg::*;

  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [NUM_CH-1:0] pinIn, timerPinOut, timerPinOe;
  logic bitIn, bitOut, bitOe, modulatorPin, clkHalved, err;
  int nErrors = 0;
  int numChecks = 0;

  tpc_top tpc_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timerPinIn(pinIn), .timerPinOut(timerPinOut), .timerPinOe(timerPinOe),
    .fourthDGroupTimerPinIn(bitIn), .fourthDGroupTimerPinOut(bitOut), .fourthDGroupTimerPinOe(bitOe),
    .modulatorPin(modulatorPin), .clkHalved(clkHalved));
  tpc_pulse_src tpc_pulse_src_inst (.clk(clk), .pin(pinIn), .bitPin(bitIn));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // A stuck slave must not hang the run, so the wait is bounded.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rv = prdata;
    err = pslverr;
    check({31'h0, k < 50}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] chAddr(input int ch, input logic [1:0] sel);
    return 12'(32'h100 + ch * 16 + 32'(sel) * 4);
  endfunction : chAddr

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Arms, reads mid-pulse, then reads the finished width twice.
  task automatic capTest(input int ch, input logic inv, input int n, input int lo, input int hi);
    tpc_pulse_src_inst.setLevel(ch, inv);
    repeat (8) @(posedge clk);
    apb(1'b1, chAddr(ch, CH_CTRL), 32'h6 | 32'(inv));
    apb(1'b0, chAddr(ch, CH_RESULT), 32'h0);
    check(rv, 32'h0);
    check({31'h0, timerPinOe[ch]}, 32'h0);
    fork
      tpc_pulse_src_inst.pulse(ch, ~inv, n);
      begin
        repeat (n / 2) @(posedge clk);
        apb(1'b0, chAddr(ch, CH_RESULT), 32'h0);
        check(rv, 32'h0);
      end
    join
    repeat (10) @(posedge clk);
    apb(1'b0, chAddr(ch, CH_RESULT), 32'h0);
    check({31'h0, rv >= lo && rv <= hi}, 32'h1);
    apb(1'b0, chAddr(ch, CH_CTRL), 32'h0);
    check(rv[CTRL_DONE_BIT], 32'h1);
    apb(1'b0, chAddr(ch, CH_RESULT), 32'h0);
    check({31'h0, rv != 0}, 32'h1);
    apb(1'b1, chAddr(ch, CH_CTRL), 32'h6 | 32'(inv));
    apb(1'b0, chAddr(ch, CH_RESULT), 32'h0);
    check(rv, 32'h0);
    apb(1'b0, chAddr(ch, CH_CTRL), 32'h0);
    check(rv[CTRL_DONE_BIT], 32'h0);
  endtask : capTest

  // Period of 8 ticks is 320 clocks at full rate; two periods are counted.
  task automatic pwmTimer();
    int c;
    for (int inv = 0; inv < 2; inv++) begin
      apb(1'b1, chAddr(1, CH_PERIOD), 32'h8);
      apb(1'b1, chAddr(1, CH_DUTY), 32'h4000);
      apb(1'b1, chAddr(1, CH_CTRL), 32'(inv));
      repeat (320) @(posedge clk);
      c = 0;
      for (int i = 0; i < 640; i++) begin
        @(posedge clk);
        if (timerPinOut[1] === 1'b1) c++;
      end
      check(32'(c), inv ? 32'd480 : 32'd160);
      check({31'h0, timerPinOe[1]}, 32'h1);
    end
  endtask : pwmTimer

  // The modulator pin has no polarity; the complemented duty ~16'h4000 gives 5 of 8 ticks high.
  task automatic pwmModulator();
    logic [15:0] d[3];
    int c;
    d = '{16'hFFFF, 16'h0000, ~16'h4000};
    apb(1'b1, REG_MOD_PERIOD, 32'h8);
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, REG_MOD_DUTY, 32'(d[j]));
      repeat (320) @(posedge clk);
      c = 0;
      for (int i = 0; i < 640; i++) begin
        @(posedge clk);
        if (modulatorPin === 1'b1) c++;
      end
      check(32'(c), d[j] == 16'hFFFF ? 32'd640 : ((32'(d[j]) * 8) >> 16) * 80);
    end
  endtask : pwmModulator

  task automatic regsAndBitIo();
    apb(1'b0, REG_CLK_CTRL, 32'h0);
    check(rv, 32'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, chAddr(13, CH_CTRL), 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, REG_BIT_IO, 32'h3);
    @(posedge clk);
    check({30'h0, bitOe, bitOut}, 32'h3);
    tpc_pulse_src_inst.setBit(1'b1);
    repeat (4) @(posedge clk);
    apb(1'b0, REG_BIT_IO, 32'h0);
    check(rv[BIO_IN_BIT], 32'h1);
  endtask : regsAndBitIo

  // Same 800-clock pulse gives 20 ticks at full rate, 10 when halved.
  task automatic halving();
    capTest(2, 1'b0, 800, 19, 21);
    apb(1'b1, REG_CLK_CTRL, 32'h1);
    @(posedge clk);
    check({31'h0, clkHalved}, 32'h1);
    capTest(2, 1'b0, 800, 9, 11);
    apb(1'b1, REG_CLK_CTRL, 32'h2);
    @(posedge clk);
    check({31'h0, clkHalved}, 32'h0);
    capTest(2, 1'b0, 800, 19, 21);
  endtask : halving

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    regsAndBitIo();
    capTest(0, 1'b0, 400, 9, 11);
    capTest(12, 1'b1, 400, 9, 11);
    halving();
    pwmTimer();
    pwmModulator();
    summarize();
  end

  // The run needs about 8300 clocks; the limit leaves ample margin.
  initial begin
    repeat (60000) @(posedge clk);
    nErrors++;
    summarize();
  end
endmodule : test_timer_pulse_width_capture
`default_nettype wire
